// ==== logic/vpm_pkg.sv ====
package vpm_pkg;
  // Exception level encodings on the current_el port.
  localparam logic [1:0] EL0 = 2'h0;
  localparam logic [1:0] EL1 = 2'h1;
  localparam logic [1:0] EL2 = 2'h2;
  localparam logic [1:0] EL3 = 2'h3;

  // System-instruction encodings of the three registers.
  localparam logic [1:0] OP0_SYS  = 2'h3;
  localparam logic [2:0] OP1_SYS  = 3'h4;
  localparam logic [3:0] CRN_SYS  = 4'ha;
  localparam logic [3:0] CRM_MAP  = 4'h6;
  localparam logic [3:0] CRM_VLD  = 4'h4;
  localparam logic [2:0] OP2_MAP6 = 3'h6;
  localparam logic [2:0] OP2_MAP7 = 3'h7;
  localparam logic [2:0] OP2_VLD  = 3'h1;

  // Save-area offsets used under memory redirection.
  localparam logic [11:0] SAVE_OFS_MAP6 = 12'h970;
  localparam logic [11:0] SAVE_OFS_MAP7 = 12'h978;
  localparam logic [11:0] SAVE_OFS_VLD  = 12'h938;

  localparam logic [5:0] TRAP_CLASS = 6'h18;

  // Presence thresholds on the highest map register index.
  localparam logic [2:0] MAP6_MIN_INDEX = 3'h5;
  localparam logic [2:0] MAP7_INDEX     = 3'h7;

  // Field layout.
  localparam int ENTRY_W     = 16;
  localparam int ENTRIES     = 8;
  localparam int PER_REG     = 4;
  localparam int VALID_W     = 32;
  localparam int FIRST_VID   = 24;
  localparam logic [1:0] COVERED_VID_HI = 2'h3;

  localparam logic TRAP_RESET = 1'b1;

  typedef enum logic [2:0] {
    VPM_DIRECT = 3'h0,
    VPM_UNDEF  = 3'h1,
    VPM_TRAP2  = 3'h3,
    VPM_TRAP3  = 3'h2,
    VPM_NESTED_VIRT_SAVE_AREA  = 3'h6
  } vpm_outcome_t;
endpackage

// ==== logic/vpm_map_regs.sv ====
`timescale 1ns/1ps
module vpm_map_regs (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [1:0]  acc_op0,
  input  wire logic [2:0]  acc_op1,
  input  wire logic [3:0]  acc_crn,
  input  wire logic [3:0]  acc_crm,
  input  wire logic [2:0]  acc_op2,
  input  wire logic [63:0] acc_wdata,
  input  wire logic [1:0]  current_el,
  input  wire logic        el2_enabled,
  input  wire logic        el3_present,
  input  wire logic        nested_virt_enable,
  input  wire logic        nested_virt_memory_redirect,
  input  wire logic        halted,
  input  wire logic        secure_debug_disable,
  input  wire logic        hypervisor_control_present,
  input  wire logic [2:0]  highest_map_register_index,
  input  wire logic        kernel_level_map_enable,
  input  wire logic        user_level_map_enable,
  input  wire logic        trap_wr,
  input  wire logic        trap_wr_value,
  input  wire logic        xlate_valid,
  input  wire logic        xlate_from_kernel,
  input  wire logic [4:0]  xlate_vid,
  output logic             acc_done,
  output logic             acc_undef,
  output logic             acc_trap,
  output logic             acc_trap_to_el3,
  output logic [5:0]       acc_trap_class,
  output logic [63:0]      acc_rdata,
  output logic             nv_mem_valid,
  output logic             nv_mem_write,
  output logic [11:0]      nv_mem_offset,
  output logic [63:0]      nv_mem_wdata,
  output logic             lower_level_access_trap,
  output logic             xlate_done,
  output logic             xlate_hit,
  output logic [15:0]      xlate_pid
);

  logic [vpm_pkg::ENTRY_W-1:0] entry_r [vpm_pkg::ENTRIES];
  logic [vpm_pkg::VALID_W-1:0] valid_r;
  logic                        trap_r;

  logic                  enc_hit;
  logic                  sel_map6;
  logic                  sel_map7;
  logic                  sel_vld;
  logic                  sel_any;
  logic                  present;
  logic                  trap3_armed;
  logic                  trap3_blocked;
  vpm_pkg::vpm_outcome_t outcome;
  logic [63:0]           read_word;
  logic [11:0]           save_ofs;

  assign enc_hit = acc_op0 == vpm_pkg::OP0_SYS && acc_op1 == vpm_pkg::OP1_SYS
                   && acc_crn == vpm_pkg::CRN_SYS;
  assign sel_map6 = enc_hit && acc_crm == vpm_pkg::CRM_MAP
                    && acc_op2 == vpm_pkg::OP2_MAP6;
  assign sel_map7 = enc_hit && acc_crm == vpm_pkg::CRM_MAP
                    && acc_op2 == vpm_pkg::OP2_MAP7;
  assign sel_vld  = enc_hit && acc_crm == vpm_pkg::CRM_VLD
                    && acc_op2 == vpm_pkg::OP2_VLD;
  assign sel_any  = sel_map6 || sel_map7 || sel_vld;

  // Index zero leaves only register 0, so both thresholds below fail.
  always_comb begin
    present = 1'b0;
    if (sel_map6) begin
      present = hypervisor_control_present
                && highest_map_register_index > vpm_pkg::MAP6_MIN_INDEX;
    end else if (sel_map7) begin
      present = hypervisor_control_present
                && highest_map_register_index == vpm_pkg::MAP7_INDEX;
    end else if (sel_vld) begin
      present = hypervisor_control_present;
    end
  end

  assign trap3_armed   = el3_present && trap_r;
  assign trap3_blocked = halted && secure_debug_disable;

  always_comb begin
    outcome = vpm_pkg::VPM_UNDEF;
    if (!present) begin
      outcome = vpm_pkg::VPM_UNDEF;
    end else begin
      unique case (current_el)
        vpm_pkg::EL0: begin
          outcome = vpm_pkg::VPM_UNDEF;
        end
        vpm_pkg::EL1: begin
          if (el2_enabled && nested_virt_enable && nested_virt_memory_redirect) begin
            outcome = vpm_pkg::VPM_NESTED_VIRT_SAVE_AREA;
          end else if (el2_enabled && nested_virt_enable) begin
            if (trap3_armed) begin
              outcome = trap3_blocked ? vpm_pkg::VPM_UNDEF : vpm_pkg::VPM_TRAP3;
            end else begin
              outcome = vpm_pkg::VPM_TRAP2;
            end
          end else begin
            outcome = vpm_pkg::VPM_UNDEF;
          end
        end
        vpm_pkg::EL2: begin
          if (trap3_armed) begin
            outcome = trap3_blocked ? vpm_pkg::VPM_UNDEF : vpm_pkg::VPM_TRAP3;
          end else begin
            outcome = vpm_pkg::VPM_DIRECT;
          end
        end
        vpm_pkg::EL3: begin
          outcome = vpm_pkg::VPM_DIRECT;
        end
      endcase
    end
  end

  always_comb begin
    read_word = 64'h0;
    save_ofs  = vpm_pkg::SAVE_OFS_VLD;
    if (sel_map6) begin
      read_word = {entry_r[3], entry_r[2], entry_r[1], entry_r[0]};
      save_ofs  = vpm_pkg::SAVE_OFS_MAP6;
    end else if (sel_map7) begin
      read_word = {entry_r[7], entry_r[6], entry_r[5], entry_r[4]};
      save_ofs  = vpm_pkg::SAVE_OFS_MAP7;
    end else begin
      read_word = {32'h0, valid_r};
    end
  end

  // The storage has no reset: software programs it before use.
  genvar g;
  generate
    for (g = 0; g < vpm_pkg::ENTRIES; g++) begin : gen_entry
      localparam int LANE = g % vpm_pkg::PER_REG;
      logic sel_mine;
      assign sel_mine = (g < vpm_pkg::PER_REG) ? sel_map6 : sel_map7;
      always_ff @(posedge clk) begin
        if (acc_valid && acc_write && sel_mine && outcome == vpm_pkg::VPM_DIRECT) begin
          entry_r[g] <= acc_wdata[LANE*vpm_pkg::ENTRY_W +: vpm_pkg::ENTRY_W];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (acc_valid && acc_write && sel_vld && outcome == vpm_pkg::VPM_DIRECT) begin
      valid_r <= acc_wdata[vpm_pkg::VALID_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trap_r <= vpm_pkg::TRAP_RESET;
    end else if (trap_wr) begin
      trap_r <= trap_wr_value;
    end
  end

  assign lower_level_access_trap = trap_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_done        <= 1'b0;
      acc_undef       <= 1'b0;
      acc_trap        <= 1'b0;
      acc_trap_to_el3 <= 1'b0;
      acc_trap_class  <= 6'h0;
      acc_rdata       <= 64'h0;
    end else begin
      acc_done        <= acc_valid && sel_any;
      acc_undef       <= acc_valid && sel_any && outcome == vpm_pkg::VPM_UNDEF;
      acc_trap        <= acc_valid && sel_any && (outcome == vpm_pkg::VPM_TRAP2
                         || outcome == vpm_pkg::VPM_TRAP3);
      acc_trap_to_el3 <= acc_valid && sel_any && outcome == vpm_pkg::VPM_TRAP3;
      acc_trap_class  <= (acc_valid && sel_any && (outcome == vpm_pkg::VPM_TRAP2
                         || outcome == vpm_pkg::VPM_TRAP3)) ? vpm_pkg::TRAP_CLASS : 6'h0;
      acc_rdata       <= (acc_valid && !acc_write && sel_any
                         && outcome == vpm_pkg::VPM_DIRECT) ? read_word : 64'h0;
    end
  end

  // The block only names the save-area slot, direction and data; the load/store unit performs it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nv_mem_valid  <= 1'b0;
      nv_mem_write  <= 1'b0;
      nv_mem_offset <= 12'h0;
      nv_mem_wdata  <= 64'h0;
    end else begin
      nv_mem_valid  <= acc_valid && sel_any && outcome == vpm_pkg::VPM_NESTED_VIRT_SAVE_AREA;
      nv_mem_write  <= acc_valid && acc_write && sel_any && outcome == vpm_pkg::VPM_NESTED_VIRT_SAVE_AREA;
      nv_mem_offset <= save_ofs;
      nv_mem_wdata  <= acc_wdata;
    end
  end

  logic [2:0] x_idx;
  logic       x_impl;
  logic       x_en;
  logic       x_hit;
  assign x_idx  = xlate_vid[2:0];
  assign x_impl = hypervisor_control_present && (x_idx[2]
                  ? highest_map_register_index == vpm_pkg::MAP7_INDEX
                  : highest_map_register_index > vpm_pkg::MAP6_MIN_INDEX);
  assign x_en   = xlate_from_kernel ? kernel_level_map_enable
                                    : user_level_map_enable;
  assign x_hit  = xlate_valid && el2_enabled && x_en && x_impl
                  && xlate_vid[4:3] == vpm_pkg::COVERED_VID_HI
                  && valid_r[xlate_vid];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xlate_done <= 1'b0;
      xlate_hit  <= 1'b0;
      xlate_pid  <= 16'h0;
    end else begin
      xlate_done <= xlate_valid;
      xlate_hit  <= x_hit;
      xlate_pid  <= x_hit ? entry_r[x_idx] : 16'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_el3_map6_write;
    acc_valid && acc_write && sel_map6 && present && current_el == vpm_pkg::EL3;
  endsequence
  sequence s_el3_map6_read;
    acc_valid && !acc_write && sel_map6 && present && current_el == vpm_pkg::EL3;
  endsequence
  sequence s_no_map6_write;
    !(acc_valid && acc_write && sel_map6);
  endsequence

  // Software leaves a gap between a write and its read-back, so the property allows one.
  a_map6_write_read: assert property (
    s_el3_map6_write ##1 s_no_map6_write ##1 s_el3_map6_read
    |=> acc_rdata == $past(acc_wdata, 3))
    else $error("map register 6 did not return its written value");
  a_el0_undef: assert property (
    acc_valid && sel_any && current_el == vpm_pkg::EL0 |=> acc_done && acc_undef)
    else $error("EL0 access was not undefined");
  a_map7_absent: assert property (
    acc_valid && sel_map7 && highest_map_register_index != vpm_pkg::MAP7_INDEX
    |=> acc_undef && !acc_trap)
    else $error("absent map register 7 was not undefined");
  a_save_offset: assert property (
    acc_valid && sel_map6 && present && current_el == vpm_pkg::EL1 && el2_enabled
    && nested_virt_enable && nested_virt_memory_redirect
    |=> nv_mem_valid && nv_mem_offset == 12'h970)
    else $error("save area slot wrong for register 6");
  a_trap_class: assert property (
    acc_trap |-> acc_trap_class == 6'h18 && !acc_undef)
    else $error("trap class wrong");
  a_sdd_undef: assert property (
    acc_valid && sel_vld && present && current_el == vpm_pkg::EL2 && el3_present
    && trap_r && halted && secure_debug_disable |=> acc_undef && !acc_trap)
    else $error("debug-disabled trap to EL3 not undefined");
  a_el3_direct: assert property (
    acc_valid && sel_any && present && current_el == vpm_pkg::EL3
    |=> acc_done && !acc_undef && !acc_trap && !nv_mem_valid)
    else $error("EL3 access not direct");
  a_vld_upper_zero: assert property (
    acc_valid && !acc_write && sel_vld |=> acc_rdata[63:32] == 32'h0)
    else $error("reserved valid bits not zero");
  a_trap_after_reset: assert property (
    $fell(sys_rst) |-> lower_level_access_trap)
    else $error("lower trap not set after reset");
  a_no_el2_no_hit: assert property (
    xlate_valid && !el2_enabled |=> xlate_done && !xlate_hit && xlate_pid == 16'h0)
    else $error("translation hit with EL2 disabled");
  a_invalid_no_hit: assert property (
    xlate_valid && !valid_r[xlate_vid] |=> !xlate_hit)
    else $error("invalid entry used");
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic        clk, sys_rst, acc_valid, acc_write, el2_enabled, el3_present, halted;
  logic        nested_virt_enable, nested_virt_memory_redirect, secure_debug_disable;
  logic        hypervisor_control_present, kernel_level_map_enable, user_level_map_enable;
  logic        trap_wr, trap_wr_value, xlate_valid, xlate_from_kernel;
  logic        acc_done, acc_undef, acc_trap, acc_trap_to_el3, nv_mem_valid, nv_mem_write;
  logic        lower_level_access_trap, xlate_done, xlate_hit, tb_trap;
  logic [1:0]  acc_op0, current_el;
  logic [2:0]  acc_op1, acc_op2, highest_map_register_index;
  logic [3:0]  acc_crn, acc_crm;
  logic [4:0]  xlate_vid;
  logic [5:0]  acc_trap_class;
  logic [11:0] nv_mem_offset;
  logic [15:0] xlate_pid;
  logic [63:0] acc_wdata, acc_rdata, nv_mem_wdata;
  logic [63:0] mdl [3];
  logic [31:0] r;
  integer      seed = 32'hb515;
  integer      fails = 0;
  integer      comparisons = 0;
  integer      i;

  vpm_map_regs dut (
    .clk                         (clk),
    .sys_rst                     (sys_rst),
    .acc_valid                   (acc_valid),
    .acc_write                   (acc_write),
    .acc_op0                     (acc_op0),
    .acc_op1                     (acc_op1),
    .acc_crn                     (acc_crn),
    .acc_crm                     (acc_crm),
    .acc_op2                     (acc_op2),
    .acc_wdata                   (acc_wdata),
    .current_el                  (current_el),
    .el2_enabled                 (el2_enabled),
    .el3_present                 (el3_present),
    .nested_virt_enable          (nested_virt_enable),
    .nested_virt_memory_redirect (nested_virt_memory_redirect),
    .halted                      (halted),
    .secure_debug_disable        (secure_debug_disable),
    .hypervisor_control_present  (hypervisor_control_present),
    .highest_map_register_index  (highest_map_register_index),
    .kernel_level_map_enable     (kernel_level_map_enable),
    .user_level_map_enable       (user_level_map_enable),
    .trap_wr                     (trap_wr),
    .trap_wr_value               (trap_wr_value),
    .xlate_valid                 (xlate_valid),
    .xlate_from_kernel           (xlate_from_kernel),
    .xlate_vid                   (xlate_vid),
    .acc_done                    (acc_done),
    .acc_undef                   (acc_undef),
    .acc_trap                    (acc_trap),
    .acc_trap_to_el3             (acc_trap_to_el3),
    .acc_trap_class              (acc_trap_class),
    .acc_rdata                   (acc_rdata),
    .nv_mem_valid                (nv_mem_valid),
    .nv_mem_write                (nv_mem_write),
    .nv_mem_offset               (nv_mem_offset),
    .nv_mem_wdata                (nv_mem_wdata),
    .lower_level_access_trap     (lower_level_access_trap),
    .xlate_done                  (xlate_done),
    .xlate_hit                   (xlate_hit),
    .xlate_pid                   (xlate_pid)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Selector 0 and 1 pick the two map registers, 2 the valid vector, 3 an unrelated encoding.
  function automatic logic present(input int s);
    logic [2:0] idx;
    idx = highest_map_register_index;
    return hypervisor_control_present && (s == 2 || (s == 0 ? idx > vpm_pkg::MAP6_MIN_INDEX
                                                            : idx == vpm_pkg::MAP7_INDEX));
  endfunction

  function automatic vpm_pkg::vpm_outcome_t outcome(input int s);
    logic t3;
    logic t3_kind;
    t3 = el3_present && tb_trap;
    t3_kind = halted && secure_debug_disable;
    if (!present(s)) return vpm_pkg::VPM_UNDEF;
    case (current_el)
      vpm_pkg::EL0: return vpm_pkg::VPM_UNDEF;
      vpm_pkg::EL1: begin
        if (el2_enabled && nested_virt_enable && nested_virt_memory_redirect)
          return vpm_pkg::VPM_NESTED_VIRT_SAVE_AREA;
        if (el2_enabled && nested_virt_enable)
          return t3 ? (t3_kind ? vpm_pkg::VPM_UNDEF : vpm_pkg::VPM_TRAP3) : vpm_pkg::VPM_TRAP2;
        return vpm_pkg::VPM_UNDEF;
      end
      vpm_pkg::EL2: return t3 ? (t3_kind ? vpm_pkg::VPM_UNDEF : vpm_pkg::VPM_TRAP3)
                              : vpm_pkg::VPM_DIRECT;
      default: return vpm_pkg::VPM_DIRECT;
    endcase
  endfunction

  task automatic access(input int s, input logic wr, input logic [63:0] d);
    vpm_pkg::vpm_outcome_t o;
    logic                  tr;
    o = outcome(s);
    tr = (o == vpm_pkg::VPM_TRAP2) || (o == vpm_pkg::VPM_TRAP3);
    acc_valid = 1'b1;
    acc_write = wr;
    acc_wdata = d;
    acc_op0 = vpm_pkg::OP0_SYS;
    acc_op1 = vpm_pkg::OP1_SYS;
    acc_crn = vpm_pkg::CRN_SYS;
    acc_crm = (s == 2) ? vpm_pkg::CRM_VLD : (s == 3) ? 4'h5 : vpm_pkg::CRM_MAP;
    acc_op2 = (s == 0) ? vpm_pkg::OP2_MAP6 : (s == 1) ? vpm_pkg::OP2_MAP7 : vpm_pkg::OP2_VLD;
    @(posedge clk);
    #1;
    acc_valid = 1'b0;
    if (s == 3) begin
      chk(acc_done, 1'b0, "foreign encoding answered");
      chk(nv_mem_valid, 1'b0, "foreign encoding redirected");
    end else if (o == vpm_pkg::VPM_NESTED_VIRT_SAVE_AREA) begin
      chk(nv_mem_valid, 1'b1, "redirect strobe");
      chk(nv_mem_write, wr, "redirect direction");
      chk(nv_mem_offset, (s == 0) ? vpm_pkg::SAVE_OFS_MAP6 : (s == 1) ? vpm_pkg::SAVE_OFS_MAP7
                                  : vpm_pkg::SAVE_OFS_VLD, "redirect offset");
      if (wr) chk(nv_mem_wdata, d, "redirect data");
    end else begin
      chk(acc_done, 1'b1, "access done");
      chk(acc_undef, o == vpm_pkg::VPM_UNDEF, "undefined flag");
      chk(acc_trap, tr, "trap flag");
      chk(acc_trap_to_el3, o == vpm_pkg::VPM_TRAP3, "trap target");
      chk(acc_trap_class, tr ? vpm_pkg::TRAP_CLASS : 6'h0, "trap class");
      if (!wr) chk(acc_rdata, (o == vpm_pkg::VPM_DIRECT) ? mdl[s] : 64'h0, "read data");
      else if (o == vpm_pkg::VPM_DIRECT) mdl[s] = (s == 2) ? {32'h0, d[31:0]} : d;
    end
    @(posedge clk);
    #1;
  endtask

  task automatic set_trap(input logic v);
    trap_wr = 1'b1;
    trap_wr_value = v;
    tb_trap = v;
    @(posedge clk);
    #1;
    trap_wr = 1'b0;
    chk(lower_level_access_trap, v, "trap bit load");
  endtask

  // Entry lookup mirrors the packing: entry v[1:0] of register v[2], lowest ID at the bottom.
  task automatic xlate(input logic [4:0] v, input logic k);
    logic        h;
    logic [15:0] p;
    h = el2_enabled && (k ? kernel_level_map_enable : user_level_map_enable) &&
        (v[4:3] == 2'h3) && present(v[2] ? 1 : 0) && mdl[2][v];
    p = h ? mdl[v[2]][v[1:0]*16 +: 16] : 16'h0;
    xlate_valid = 1'b1;
    xlate_vid = v;
    xlate_from_kernel = k;
    @(posedge clk);
    #1;
    xlate_valid = 1'b0;
    chk(xlate_done, 1'b1, "lookup done");
    chk(xlate_hit, h, "lookup hit");
    chk(xlate_pid, p, "lookup id");
    @(posedge clk);
    #1;
  endtask

  initial begin
    {acc_valid, acc_write, el2_enabled, el3_present, halted, nested_virt_enable} = '0;
    {nested_virt_memory_redirect, secure_debug_disable, hypervisor_control_present} = '0;
    {kernel_level_map_enable, user_level_map_enable, trap_wr, trap_wr_value} = '0;
    {xlate_valid, xlate_from_kernel, acc_op0, current_el, acc_op1, acc_op2} = '0;
    {highest_map_register_index, acc_crn, acc_crm, xlate_vid, acc_wdata} = '0;
    sys_rst = 1'b1;
    tb_trap = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    chk(lower_level_access_trap, 1'b1, "trap bit at reset");
    chk(acc_done, 1'b0, "idle at reset");
    sys_rst = 1'b0;
    hypervisor_control_present = 1'b1;
    highest_map_register_index = 3'h7;
    {el3_present, el2_enabled, current_el} = {2'h3, vpm_pkg::EL3};
    access(2, 1'b1, 64'hffffffffffffffff);
    access(2, 0, 64'h0);
    for (i = 0; i < 3; i++) begin
      r = $random(seed);
      access(i, 1'b1, {r, ~r ^ 32'h5a5a0f0f});
      access(i, 1'b0, 64'h0);
    end
    $display("test setup done");
    {kernel_level_map_enable, user_level_map_enable} = 2'h3;
    for (i = 0; i < 64; i++) xlate(i[4:0], i[5]);
    $display("test lookup sweep done");
    // Rare combinations that random draws seldom reach.
    set_trap(1'b1);
    {current_el, el2_enabled, nested_virt_enable, nested_virt_memory_redirect} = {vpm_pkg::EL1, 3'h7};
    access(0, 1'b1, 64'h0123456789abcdef);
    {current_el, halted, secure_debug_disable} = {vpm_pkg::EL2, 2'h3};
    access(2, 1'b1, 64'h0);
    {current_el, nested_virt_memory_redirect, halted} = {vpm_pkg::EL1, 2'h0};
    access(1, 1'b0, 64'h0);
    set_trap(1'b0);
    access(1, 1'b0, 64'h0);
    $display("test corner cases done");
    for (i = 0; i < 400; i++) begin
      r = $random(seed);
      set_trap(r[31]);
      {current_el, el2_enabled, nested_virt_enable, nested_virt_memory_redirect} = r[4:0];
      {halted, secure_debug_disable, el3_present} = {r[5], r[6], r[7] | r[8]};
      hypervisor_control_present = r[11:9] != 3'h0;
      highest_map_register_index = r[14:12];
      {kernel_level_map_enable, user_level_map_enable} = r[16:15];
      access(r[18:17], r[19], {$random(seed), r});
      r = $random(seed);
      xlate(r[4:0], r[5]);
    end
    $display("test random access done");
    sys_rst = 1'b1;
    #20;
    chk(lower_level_access_trap, 1'b1, "trap bit after second reset");
    $display("test second reset done");
    final_report;
  end

  initial begin
    #200000;
    fails++;
    $display("BAD t=%0t watchdog expired", $time);
    final_report;
  end
endmodule
